// [hdl/hub_defs.vh]
`ifndef HUB_DEFS_VH
`define HUB_DEFS_VH

// Register byte offsets
`define HUB_OFS_CTRL 12'h000
`define HUB_OFS_STAT 12'h004
`define HUB_OFS_IDLE 12'h008

// Control register fields
`define HUB_CTRL_REQ_LSB 0
`define HUB_CTRL_REQ_MSB 3
`define HUB_CTRL_FORCE 8
`define HUB_CTRL_RST 4'hf

// Status register fields
`define HUB_STAT_APPLIED_LSB 0
`define HUB_STAT_PEND_LSB 4
`define HUB_STAT_PIN_LSB 8
`define HUB_STAT_PIDLE_LSB 12
`define HUB_STAT_CIDLE 17
`define HUB_STAT_SHARE_LSB 18

// Bus-free time before a gate may change
`define HUB_IDLE_NS 50000
`define HUB_CLK_MHZ 125
`define HUB_CNT_W 16

// Synchronised input vector width
`define HUB_SYNC_W 18

`endif

// [hdl/hub_sync.v]
`timescale 1ns/1ps
`default_nettype none
module hub_sync #(
  parameter W = 18
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Raw pins and filtered levels
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // Idle level of an open-drain line is high, so reset there
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          lvl_q <= 1'b1;
        end else begin
          s1_q <= d_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign q_out[i] = lvl_q;
    end
  endgenerate

endmodule // hub_sync
`default_nettype wire

// [hdl/hub_ctl.v]
// Behaviour
// (RQ1) Hub repeats data and clock lines as two shared open-drain buffers.
// (RQ2) A low on any enabled port appears on every other enabled port.
// (RQ3) Hub ignores its own driven low as a new incoming low.
// (RQ4) Gates 1 to 4 are active high with pull-ups; released means enabled.
// (RQ5) A low gate isolates that port's inputs and drivers.
// (RQ6) Change a gate only while cluster and that port are both idle; with force_q set the code changes it without waiting.
// (RQ7) Port 0 has no gate and always takes part.
// (RQ8) Hub has four open-drain share lines, two data, two clock.
// (RQ9) Each share line is wired to the same line of every hub.
// (RQ10) System pulls up all four share lines, even with one hub.
// (RQ11) Arbitration and clock stretching pass transparently between segments.
// (RQ12) Hub works from static up to fast-mode clock rates.
// (RQ13) Gate inputs accept wired open-drain drivers from several controllers.
// (RQ14) Share line a falls whenever any data (or clock) port goes low.
// (RQ15) Share line b falls while an outside driver holds a port low.
// (RQ16) Share line low pulls all other enabled ports to buffered low.
// (RQ17) Release order: line b first, then line a, then remaining ports; hub_dev_model releases them all together.
// (RQ18) Lines model as wired-AND of enabled ports and share lines.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "hub_defs.vh"
module hub_ctl #(
  parameter [15:0] IDLE_CYC = (`HUB_IDLE_NS * `HUB_CLK_MHZ + 999) / 1000
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Hub port lines, observed only
  input wire [4:0] sda_in,
  input wire [4:0] scl_in,
  // Cluster share lines, observed only
  input wire data_share_line_a,
  input wire data_share_line_b,
  input wire clock_share_line_a,
  input wire clock_share_line_b,
  // Open-drain gate pins for ports 1 to 4
  input wire [3:0] port_gate_in,
  output reg [3:0] port_gate_out,
  output reg [3:0] port_gate_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  wire [`HUB_SYNC_W-1:0] raw_in;
  wire [`HUB_SYNC_W-1:0] flt;
  wire [4:0] sda_s;
  wire [4:0] scl_s;
  wire [3:0] share_s;
  wire [3:0] gate_pin_s;

  // Share lines are only watched, never driven, so the cluster owns them
  // (RQ9) shared cluster wiring
  // (RQ10) external pull-ups assumed
  assign raw_in = {port_gate_in, clock_share_line_b, clock_share_line_a,
                   data_share_line_b, data_share_line_a, scl_in, sda_in};

  hub_sync #(
    .W(`HUB_SYNC_W)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d_in(raw_in),
    .q_out(flt)
  );

  assign sda_s = flt[4:0];
  assign scl_s = flt[9:5];
  assign share_s = flt[13:10];
  assign gate_pin_s = flt[17:14];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [3:0] req_q;
  reg force_q;
  wire ctrl_hit;
  wire stat_hit;
  wire idle_hit;
  wire setup;
  wire access_done;
  reg [31:0] rd_d;
  reg [31:0] stat_val;
  wire [4:0] port_idle;
  wire [3:0] pend;
  reg clu_idle_q;

  assign ctrl_hit = (paddr == `HUB_OFS_CTRL);
  assign stat_hit = (paddr == `HUB_OFS_STAT);
  assign idle_hit = (paddr == `HUB_OFS_IDLE);
  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready;

  // Status word, field by field
  always @* begin
    stat_val = 32'h00000000;
    stat_val[`HUB_STAT_APPLIED_LSB +: 4] = ~port_gate_oe;
    stat_val[`HUB_STAT_PEND_LSB +: 4] = pend;
    stat_val[`HUB_STAT_PIN_LSB +: 4] = gate_pin_s;
    stat_val[`HUB_STAT_PIDLE_LSB +: 5] = port_idle;
    stat_val[`HUB_STAT_CIDLE] = clu_idle_q;
    stat_val[`HUB_STAT_SHARE_LSB +: 4] = share_s;
  end

  always @* begin
    rd_d = 32'h00000000;
    if (ctrl_hit) begin
      rd_d[`HUB_CTRL_REQ_MSB:`HUB_CTRL_REQ_LSB] = req_q;
      rd_d[`HUB_CTRL_FORCE] = force_q;
    end else if (stat_hit) begin
      rd_d = stat_val;
    end else if (idle_hit) begin
      rd_d = {16'h0000, IDLE_CYC};
    end
  end

  // Answer in the first access cycle; registered so outputs come from flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_d;
        pslverr <= ~(ctrl_hit | stat_hit | idle_hit) |
                   (pwrite & (stat_hit | idle_hit));
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Default request leaves every gate enabled, as the pull-ups would
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= `HUB_CTRL_RST;
      force_q <= 1'b0;
    end else if (access_done & pwrite & ctrl_hit) begin
      req_q <= pwdata[`HUB_CTRL_REQ_MSB:`HUB_CTRL_REQ_LSB];
      force_q <= pwdata[`HUB_CTRL_FORCE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle detection

  // Idle is a high-time count, so any clock rate down to static is covered
  // (RQ12) rate independent idle
  genvar p;
  generate
    for (p = 0; p < 5; p = p + 1) begin : g_port
      reg [`HUB_CNT_W-1:0] cnt_q;
      // (RQ7) port 0 watched too
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_q <= {`HUB_CNT_W{1'b0}};
        end else if (!(sda_s[p] & scl_s[p])) begin
          cnt_q <= {`HUB_CNT_W{1'b0}};
        end else if (cnt_q != IDLE_CYC) begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
      assign port_idle[p] = (cnt_q == IDLE_CYC);
    end
  endgenerate

  reg [`HUB_CNT_W-1:0] clu_cnt_q;

  // Share lines carry every enabled port's low, so they stand for the global bus
  // (RQ14) share line activity
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clu_cnt_q <= {`HUB_CNT_W{1'b0}};
      clu_idle_q <= 1'b0;
    end else begin
      if (share_s != 4'hf) begin
        clu_cnt_q <= {`HUB_CNT_W{1'b0}};
      end else if (clu_cnt_q != IDLE_CYC) begin
        clu_cnt_q <= clu_cnt_q + 16'h0001;
      end
      clu_idle_q <= (share_s == 4'hf) & (clu_cnt_q == IDLE_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drivers

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_gate
      assign pend[g] = (req_q[g] == port_gate_oe[g]);
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          port_gate_oe[g] <= 1'b0;
          port_gate_out[g] <= 1'b0;
        end else begin
          port_gate_out[g] <= 1'b0;
          // (RQ6) wait for idle
          if (pend[g] & (force_q | (clu_idle_q & port_idle[g + 1]))) begin
            // (RQ13) release or pull low
            port_gate_oe[g] <= ~req_q[g];
          end
        end
      end
    end
  endgenerate

endmodule // hub_ctl
`default_nettype wire

// [tb/hub_ctl_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module hub_ctl_sva #(
  parameter int IDLE_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Share lines and gate pins
  input wire logic data_share_line_a,
  input wire logic data_share_line_b,
  input wire logic clock_share_line_a,
  input wire logic clock_share_line_b,
  input wire logic [3:0] port_gate_out,
  input wire logic [3:0] port_gate_oe
);
  int hi_q;
  int ago_q;
  logic frc_q;
  logic all_hi;
  assign all_hi = data_share_line_a & data_share_line_b & clock_share_line_a & clock_share_line_b;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  // Pins lead the synced view, so a short grace is allowed
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_q <= 0;
      ago_q <= 99;
      frc_q <= 1'b0;
    end else begin
      hi_q <= all_hi ? ((hi_q < IDLE_CYC) ? hi_q + 1 : hi_q) : 0;
      ago_q <= (hi_q >= IDLE_CYC) ? 0 : ((ago_q < 99) ? ago_q + 1 : ago_q);
      if (psel && penable && pready && pwrite && paddr == 12'h000) begin
        frc_q <= pwdata[8];
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  rdy_one_a: assert property (setup_s |=> answer_s) else $error("APB answer not one cycle");
  unmapped_err_a: assert property (setup_s ##0 paddr > 12'h008 |=> pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused");
  gate_drain_a: assert property (port_gate_out == 4'h0)
    else $error("Gate pin driven high");
  gate_idle_a: assert property (!frc_q && $changed(port_gate_oe) |-> ago_q < 8)
    else $error("Gate changed while bus busy");
endmodule // hub_ctl_sva
bind hub_ctl hub_ctl_sva #(.IDLE_CYC(IDLE_CYC)) u_sva (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .data_share_line_a(data_share_line_a),
  .data_share_line_b(data_share_line_b), .clock_share_line_a(clock_share_line_a),
  .clock_share_line_b(clock_share_line_b), .port_gate_out(port_gate_out),
  .port_gate_oe(port_gate_oe));
`default_nettype wire

// [tb/hub_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hub_dev_model (
  // Gate pin levels, ports 1 to 4
  input wire logic [3:0] port_gate,
  // Outside drivers pulling ports low
  input wire logic [4:0] sda_pull,
  input wire logic [4:0] scl_pull,
  // Port and share line levels
  output logic [4:0] sda,
  output logic [4:0] scl,
  output logic [3:0] cluster_share_line
);
  logic [4:0] en;
  assign en = {port_gate, 1'b1};
  assign cluster_share_line = {{2{~|(scl_pull & en)}}, {2{~|(sda_pull & en)}}};
  // Clockless wired-AND
  // Zero delay, so both share lines and all ports release together
  assign sda = ~(sda_pull | (en & {5{~cluster_share_line[0]}}));
  assign scl = ~(scl_pull | (en & {5{~cluster_share_line[2]}}));
endmodule // hub_dev_model
`default_nettype wire

// [tb/test_hub_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
module test_hub_ctl;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] sda_pull, scl_pull, sda, scl;
  logic [3:0] gout, goe, gate_w, shl;
  int num_errors, checked;
  assign gate_w = ~(goe & ~gout);
  // Single hub, share lines pulled up
  hub_dev_model dev (.port_gate(gate_w), .sda_pull(sda_pull), .scl_pull(scl_pull), .sda(sda),
    .scl(scl), .cluster_share_line(shl));
  hub_ctl #(.IDLE_CYC(16'd20)) DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sda_in(sda), .scl_in(scl), .data_share_line_a(shl[0]),
    .data_share_line_b(shl[1]), .clock_share_line_a(shl[2]), .clock_share_line_b(shl[3]),
    .port_gate_in(gate_w), .port_gate_out(gout), .port_gate_oe(goe));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 300) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 300);
    tmo(n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input logic [3:0] v);
    int n;
    n = 0;
    while (goe !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, sda_pull, scl_pull} = '0;
    num_errors = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    chk("oe_reset", goe, 32'h0);
    apb(0, 12'h000, 0);
    chk("ctrl_reset", rd, 32'hf);
    apb(0, 12'h008, 0);
    chk("idle_reg", rd, 32'h14);
    apb(0, 12'h010, 0);
    chk("unmapped_err", er, 32'h1);
    apb(1, 12'h004, 0);
    chk("ro_err", er, 32'h1);
    // Idle bus: gate off port 1
    apb(1, 12'h000, 32'he);
    wt(4'h1);
    // Let the gate pin level pass the input filter before reading status
    repeat (4) @(posedge clk);
    apb(0, 12'h004, 0);
    chk("stat", rd, 32'h003ffe0e);
    // Busy data line holds the change; wait until the filtered view is busy
    sda_pull <= 5'h01;
    repeat (8) @(posedge clk);
    apb(1, 12'h000, 32'hf);
    repeat (60) @(posedge clk);
    chk("held", goe, 4'h1);
    apb(0, 12'h004, 0);
    chk("pending", rd[4], 32'h1);
    chk("busy_stat", rd[21:17], 32'h18);
    // Force skips the idle wait
    apb(1, 12'h000, 32'h10f);
    wt(4'h0);
    // Busy clock line holds the next change
    sda_pull <= 5'h00;
    scl_pull <= 5'h01;
    apb(1, 12'h000, 32'h7);
    repeat (60) @(posedge clk);
    chk("held_clk", goe, 4'h0);
    scl_pull <= 5'h00;
    wt(4'h8);
    chk("applied", goe, 4'h8);
    chk("gate_drive", gout, 4'h0);
    // Mid-run reset releases every gate and restores the request word
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("oe_rst2", goe, 4'h0);
    arst_n <= 1'b1;
    apb(0, 12'h000, 0);
    chk("ctrl_rst2", rd, 32'hf);
    chk("oe_after", goe, 4'h0);
    tally_and_finish();
  end
endmodule // test_hub_ctl
`default_nettype wire
